/* core/pdac_master.sv */
`timescale 1ns/10ps
module pdac_master (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic LOCAL_WIDE_REQUEST_N_I,
  input wire logic LOCAL_NARROW_REQUEST_N_I,
  input wire logic [63:0] LOCAL_ADDRESS_I,
  input wire logic [7:0] LOCAL_COMMAND_I,
  input wire logic LOCAL_LAST_N_I,
  input wire logic MABORT_CLEAR_I,
  input wire logic GNT_N_I,
  input wire logic DEVSEL_N_I,
  input wire logic TRDY_N_I,
  input wire logic STOP_N_I,
  output logic LOCAL_ADDRESS_ACCEPT_N_O,
  output logic LOCAL_DATA_PHASE_O,
  output logic REQ_N_O,
  output logic FRAME_N_O,
  output logic FRAME_OE_N_O,
  output logic REQ64_N_O,
  output logic IRDY_N_O,
  output logic [63:0] AD_O,
  output logic AD_OE_N_O,
  output logic [7:0] CBE_N_O,
  output logic MABORT_RCVD_O
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pdac_pkg::pdac_state_e state_reg, state_next;
  logic [63:0] addr_reg;
  logic [7:0] cmd_reg;
  logic wide_reg;
  logic [2:0] wait_reg, wait_next;
  logic claimed_reg, claimed_next;
  logic mabort_reg;
  logic [63:0] ad_reg;
  logic [7:0] cbe_reg;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire local_req = ~LOCAL_WIDE_REQUEST_N_I | ~LOCAL_NARROW_REQUEST_N_I;
  wire in_req = state_reg == pdac_pkg::ST_REQ;
  wire in_a1 = state_reg == pdac_pkg::ST_ADDR1;
  wire in_a2 = state_reg == pdac_pkg::ST_ADDR2;
  wire in_data = state_reg == pdac_pkg::ST_DATA;
  wire granted = in_req & ~GNT_N_I;
  wire data_done = in_data & ~DEVSEL_N_I & (~TRDY_N_I | ~STOP_N_I) & (~LOCAL_LAST_N_I
    | ~STOP_N_I);
  wire abort_evt = in_data & ~claimed_reg & DEVSEL_N_I & (wait_reg == pdac_pkg::CNT_ONE);
  wire in_state_idle_req = (state_reg == pdac_pkg::ST_IDLE) & local_req;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    claimed_next = claimed_reg | (in_data & ~DEVSEL_N_I);
    unique case (state_reg)
      pdac_pkg::ST_IDLE: begin
        if (local_req) begin
          state_next = pdac_pkg::ST_REQ;
        end
      end
      pdac_pkg::ST_REQ: begin
        if (granted) begin
          state_next = pdac_pkg::ST_ADDR1;
        end
      end
      pdac_pkg::ST_ADDR1: begin
        state_next = pdac_pkg::ST_ADDR2;
      end
      pdac_pkg::ST_ADDR2: begin
        state_next = pdac_pkg::ST_DATA;
        wait_next = pdac_pkg::DEVSEL_WAIT_CYC;
        claimed_next = 1'b0;
      end
      pdac_pkg::ST_DATA: begin
        if (wait_reg != pdac_pkg::CNT_ZERO) begin
          wait_next = wait_reg - pdac_pkg::CNT_ONE;
        end
        if (data_done || abort_evt) begin
          state_next = pdac_pkg::ST_TURN;
        end
      end
      pdac_pkg::ST_TURN: begin
        state_next = pdac_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      state_reg <= pdac_pkg::ST_IDLE;
      wait_reg <= pdac_pkg::CNT_ZERO;
      claimed_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      claimed_reg <= claimed_next;
    end
  end

  // address and command captured while accept is shown
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      addr_reg <= 64'h0;
      cmd_reg <= 8'hff;
      wide_reg <= 1'b0;
    end else if (in_req) begin
      addr_reg <= LOCAL_ADDRESS_I;
      cmd_reg <= LOCAL_COMMAND_I;
      wide_reg <= ~LOCAL_WIDE_REQUEST_N_I;
    end
  end

  // set wins over clear
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      mabort_reg <= 1'b0;
    end else if (abort_evt) begin
      mabort_reg <= 1'b1;
    end else if (MABORT_CLEAR_I) begin
      mabort_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // bus drive
  // ---------------------------------------------------------------
  wire [63:0] ad_first = LOCAL_ADDRESS_I;
  wire [63:0] ad_a2 = {addr_reg[63:32], addr_reg[63:32]};
  wire [7:0] cbe_first = {LOCAL_COMMAND_I[7:4], pdac_pkg::CMD_DAC};
  wire [7:0] cbe_a2 = {cmd_reg[7:4], cmd_reg[7:4]};
  // launched one edge ahead so the bus is driven from flip-flops
  wire [63:0] ad_next = granted ? ad_first
    : in_a1 ? ad_a2 : 64'h0;
  wire [7:0] cbe_next = granted ? cbe_first
    : in_a1 ? cbe_a2 : 8'hff;

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      ad_reg <= 64'h0;
      cbe_reg <= 8'hff;
    end else begin
      ad_reg <= ad_next;
      cbe_reg <= cbe_next;
    end
  end

  assign LOCAL_ADDRESS_ACCEPT_N_O = ~in_req;
  assign REQ_N_O = ~in_req;
  assign FRAME_N_O = ~(in_a1 | in_a2 | (in_data & ~data_done & ~abort_evt));
  assign FRAME_OE_N_O = ~(in_a1 | in_a2 | in_data | (state_reg == pdac_pkg::ST_TURN));
  assign REQ64_N_O = ~(wide_reg & (in_a1 | in_a2 | in_data));
  assign IRDY_N_O = ~in_data;
  assign LOCAL_DATA_PHASE_O = in_data;
  assign AD_O = ad_reg;
  assign AD_OE_N_O = ~(in_a1 | in_a2);
  assign CBE_N_O = cbe_reg;
  assign MABORT_RCVD_O = mabort_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence dual_phase_s;
    !FRAME_N_O && CBE_N_O[3:0] == pdac_pkg::CMD_DAC ##1 !FRAME_N_O && AD_O[31:0] == AD_O[63:32];
  endsequence

  sequence req_wait_s;
    !REQ_N_O && !LOCAL_ADDRESS_ACCEPT_N_O;
  endsequence

  // five unclaimed data cycles, the devsel wait
  sequence unclaimed_s;
    in_a2 ##1 (in_data && DEVSEL_N_I) [*5];
  endsequence

  grant_addr_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    granted |=> dual_phase_s) else $error("dual address cycle not issued after grant");
  frame_first_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    $fell(FRAME_N_O) |-> in_a1) else $error("frame not asserted in first address phase");
  phase_one_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    in_a1 |-> AD_O == $past(LOCAL_ADDRESS_I) && CBE_N_O[7:4] == $past(LOCAL_COMMAND_I[7:4]))
    else $error("first address phase content wrong");
  phase_two_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    in_a1 |=> AD_O == {$past(AD_O[63:32]), $past(AD_O[63:32])} && CBE_N_O[3:0] == CBE_N_O[7:4])
    else $error("second address phase content wrong");
  req_out_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    in_state_idle_req |=> !REQ_N_O) else $error("bus request not raised");
  accept_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    in_state_idle_req |=> !LOCAL_ADDRESS_ACCEPT_N_O) else $error("request not acknowledged");
  req_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    !REQ_N_O && GNT_N_I |=> req_wait_s)
    else $error("request or accept dropped before grant");
  busy_no_req_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    !FRAME_OE_N_O |-> REQ_N_O) else $error("bus request raised while busy");
  addr_drive_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    $fell(FRAME_N_O) |-> !AD_OE_N_O ##1 !AD_OE_N_O) else $error("address bus not driven");
  wide_flag_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    $fell(FRAME_N_O) |-> REQ64_N_O == !wide_reg) else $error("wide request flag wrong");
  data_follow_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    in_a2 |=> !IRDY_N_O) else $error("data phase does not follow address phases");
  mabort_set_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    abort_evt |=> MABORT_RCVD_O && state_reg == pdac_pkg::ST_TURN)
    else $error("master abort not flagged");
  mabort_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    MABORT_RCVD_O && !MABORT_CLEAR_I |=> MABORT_RCVD_O) else $error("abort flag lost");
  abort_time_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    unclaimed_s |=> MABORT_RCVD_O && FRAME_N_O)
    else $error("master abort not taken after devsel wait");
  mabort_clear_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    !abort_evt && MABORT_CLEAR_I |=> !MABORT_RCVD_O)
    else $error("abort flag not cleared");
  idle_bus_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    state_reg == pdac_pkg::ST_TURN |=> FRAME_OE_N_O && AD_O == 64'h0 && CBE_N_O == 8'hff)
    else $error("bus not released after turnaround");
endmodule : pdac_master

/* pkg/pdac_pkg.sv */
package pdac_pkg;
  // ---------------------------------------------------------------
  // bus command codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_DAC = 4'hd;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_CFG_READ = 4'ha;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  // nanoseconds after the second address phase before master abort, rounded up to cycles
  localparam int DEVSEL_WAIT_NS = 20;
  localparam logic [2:0] DEVSEL_WAIT_CYC = 3'((DEVSEL_WAIT_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS);
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_ADDR1,
    ST_ADDR2,
    ST_DATA,
    ST_TURN
  } pdac_state_e;
endpackage : pdac_pkg

/* tb/pdac_bus_model.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// arbiter and target agent
// ---------------------------------------------------------------
module pdac_bus_model (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic REQ_N_I,
  input wire logic IRDY_N_I,
  input wire logic CLAIM_I,
  output logic GNT_N_O,
  output logic DEVSEL_N_O,
  output logic TRDY_N_O,
  output logic STOP_N_O
);
  // grant one cycle after the bus request
  always_ff @(posedge CLOCK_I) begin
    GNT_N_O <= !RESET_N_I || REQ_N_I;
  end
  // claim only when told to, else leave it to master abort
  assign DEVSEL_N_O = !(CLAIM_I && !IRDY_N_I);
  assign TRDY_N_O = DEVSEL_N_O;
  assign STOP_N_O = 1'b1;
endmodule : pdac_bus_model

/* tb/pdac_master_tb_top.sv */
`timescale 1ns/10ps
module pdac_master_tb_top;
  logic clk, rst_n, wide_n, narrow_n, last_n, clr, claim, gnt_n, devsel_n, trdy_n, stop_n;
  logic accept_n, data_ph, req_n, frame_n, frame_oe_n, req64_n, irdy_n, ad_oe_n, mabort;
  logic [63:0] addr, ad;
  logic [7:0] cmd, cbe_n;
  int errors, num_checks;
  pdac_master i_pdac_master (.CLOCK_I(clk), .RESET_N_I(rst_n), .LOCAL_WIDE_REQUEST_N_I(wide_n),
    .LOCAL_NARROW_REQUEST_N_I(narrow_n), .LOCAL_ADDRESS_I(addr), .LOCAL_COMMAND_I(cmd),
    .LOCAL_LAST_N_I(last_n), .MABORT_CLEAR_I(clr), .GNT_N_I(gnt_n), .DEVSEL_N_I(devsel_n),
    .TRDY_N_I(trdy_n), .STOP_N_I(stop_n), .LOCAL_ADDRESS_ACCEPT_N_O(accept_n),
    .LOCAL_DATA_PHASE_O(data_ph), .REQ_N_O(req_n), .FRAME_N_O(frame_n),
    .FRAME_OE_N_O(frame_oe_n), .REQ64_N_O(req64_n), .IRDY_N_O(irdy_n), .AD_O(ad),
    .AD_OE_N_O(ad_oe_n), .CBE_N_O(cbe_n), .MABORT_RCVD_O(mabort));
  pdac_bus_model i_pdac_bus_model (.CLOCK_I(clk), .RESET_N_I(rst_n), .REQ_N_I(req_n),
    .IRDY_N_I(irdy_n), .CLAIM_I(claim), .GNT_N_O(gnt_n), .DEVSEL_N_O(devsel_n),
    .TRDY_N_O(trdy_n), .STOP_N_O(stop_n));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task chk_cmd(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t command got %h expected %h", $time, got, exp);
    end
  endtask : chk_cmd
  task chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task step;
    @(posedge clk);
    #1;
  endtask : step
  task wait_oe(input logic lvl);
    int n;
    for (n = 0; n < 20 && frame_oe_n !== lvl; n++) step();
    if (frame_oe_n !== lvl) begin
      errors++;
      $display("BAD %0t frame enable wait ran out", $time);
      results();
    end
  endtask : wait_oe
  task dac_cycle(input logic wide, input logic [3:0] c, input logic [63:0] a, input logic clm,
    input int beats);
    int n;
    @(posedge clk);
    wide_n <= !wide;
    narrow_n <= wide;
    addr <= a;
    cmd <= {c, pdac_pkg::CMD_DAC};
    claim <= clm;
    last_n <= beats > 1 ? 1'b1 : 1'b0;
    step();
    chk_bit(req_n, 1'b0);
    chk_bit(accept_n, 1'b0);
    wait_oe(1'b0);
    chk_bit(frame_n, 1'b0);
    chk_bit(ad_oe_n, 1'b0);
    chk(ad, a);
    chk_cmd(cbe_n, {c, pdac_pkg::CMD_DAC});
    chk_bit(req64_n, !wide);
    chk_bit(req_n, 1'b1);
    @(posedge clk);
    wide_n <= 1'b1;
    narrow_n <= 1'b1;
    #1;
    chk_bit(frame_n, 1'b0);
    chk_bit(ad_oe_n, 1'b0);
    chk(ad, {a[63:32], a[63:32]});
    chk_cmd(cbe_n, {c, c});
    step();
    chk_bit(irdy_n, 1'b0);
    chk_bit(data_ph, 1'b1);
    chk_bit(ad_oe_n, 1'b1);
    for (n = 1; n < beats; n++) begin
      chk_bit(frame_n, 1'b0);
      @(posedge clk);
      if (n == beats - 1) last_n <= 1'b0;
      #1;
      chk_bit(irdy_n, 1'b0);
    end
    if (clm) begin
      chk_bit(frame_n, 1'b1);
    end else begin
      repeat (pdac_pkg::DEVSEL_WAIT_CYC - 2) step();
      chk_bit(frame_n, 1'b0);
      step();
      chk_bit(frame_n, 1'b1);
    end
    wait_oe(1'b1);
    chk_bit(data_ph, 1'b0);
    repeat (3) step();
    chk_bit(mabort, !clm);
  endtask : dac_cycle
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task sc_wide_back_to_back;
    dac_cycle(1'b1, pdac_pkg::CMD_MEM_READ, 64'hfedc_ba98_7654_3210, 1'b1, 1);
    dac_cycle(1'b1, pdac_pkg::CMD_MEM_WRITE, 64'h0000_0001_ffff_fffc, 1'b1, 3);
  endtask : sc_wide_back_to_back
  task sc_narrow_abort;
    dac_cycle(1'b0, pdac_pkg::CMD_CFG_READ, 64'h8000_0000_0000_0010, 1'b1, 2);
    dac_cycle(1'b0, pdac_pkg::CMD_CFG_WRITE, 64'h1234_5678_9abc_def0, 1'b0, 1);
    repeat (4) step();
    chk_bit(mabort, 1'b1);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    step();
    chk_bit(mabort, 1'b0);
  endtask : sc_narrow_abort
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    wide_n = 1'b1;
    narrow_n = 1'b1;
    last_n = 1'b0;
    clr = 1'b0;
    claim = 1'b0;
    addr = 64'h0;
    cmd = 8'h0;
    errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    sc_wide_back_to_back();
    sc_narrow_abort();
    results();
  end
endmodule : pdac_master_tb_top
